/* hw/bcie_core.sv */
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
// Function
// - upper nibble operation, lower nibble addressing mode
// - complement carry only
// - invert destination, z s set, v cleared
// - decrement byte, carry untouched
// - compare sets flags, no write back
// - or into destination, v cleared
// - increment byte, short and long forms
// - increment register pair as word
// - pull from stack, pointer up one
// - pointer down one, then push
// - return pops program counter, pointer plus two
// - clear carry only
// - set carry only
// - immediate loads working group pointer
// - code byte copy, both pointers incremented
// - restore flags, pop pc, enable interrupts
// - register space layout with expanded registers
// - flags live in control register file
// - condition code 1111 means carry clear
module bcie_core #(
  parameter logic [15:0] RESET_PC = 16'h0000
) (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [bcie_p::APB_AW-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // program memory
  output logic [15:0]                    pmem_addr,
  input  wire logic [7:0]                pmem_rdata
);
  bcie_p::bcie_core_t q;
  bcie_p::bcie_core_t n;
  // opcode fields and special registers
  logic [3:0]  hi;
  logic [3:0]  lo;
  logic [7:0]  rp;
  logic [7:0]  sp;
  logic [7:0]  flg;
  logic [7:0]  r_hi;
  logic [7:0]  r_lo;
  logic [7:0]  r_opc;
  logic [7:0]  rr_a;
  logic [7:0]  d1;
  logic [7:0]  d2;

  // operand addressing
  logic [7:0]  dst_a;
  logic [7:0]  src_v;
  logic [7:0]  wadr;

  // program counter and word arithmetic
  logic [15:0] pc_next;
  logic [15:0] pc_rel;
  logic [15:0] wval;
  logic [15:0] wnew;

  // alu hookup
  logic        un1;
  logic        alu_un;
  logic        alu_ok;
  logic [3:0]  alu_nib;
  logic [7:0]  alu_res;
  logic [7:0]  alu_f;
  logic        alu_wb;

  // register bus decode
  logic        apb_acc;
  logic [1:0]  erf_i;

  // short register numbers in the working window map onto the group
  function automatic logic [7:0] wmap(input logic [7:0] x, input logic [7:0] p);
    return (x[7:4] == bcie_p::WREG_NIB) ? {p[7:4], x[3:0]} : x;
  endfunction : wmap

  // condition code test, top bit inverts the sense
  function automatic logic cc_true(input logic [3:0] cc, input logic [7:0] f);
    logic c;
    logic z;
    logic s;
    logic v;
    logic b;
    c = f[bcie_p::FL_C];
    z = f[bcie_p::FL_Z];
    s = f[bcie_p::FL_S];
    v = f[bcie_p::FL_V];
    case (cc[2:0])
      3'h0: b = 1'b0;
      3'h1: b = s ^ v;
      3'h2: b = z | (s ^ v);
      3'h3: b = c | z;
      3'h4: b = v;
      3'h5: b = s;
      3'h6: b = z;
      default: b = c;
    endcase
    return b ^ cc[3];
  endfunction : cc_true

  // instruction length from the lower opcode nibble
  function automatic logic [15:0] ins_len(input logic [3:0] l);
    case (l)
      bcie_p::LN_INCR, bcie_p::LN_ONE: ins_len = bcie_p::LEN1;
      bcie_p::LN_RR3, bcie_p::LN_RIRR, bcie_p::LN_RIM, bcie_p::LN_IRIM,
      bcie_p::LN_JP: ins_len = bcie_p::LEN3;
      default: ins_len = bcie_p::LEN2;
    endcase
  endfunction : ins_len

  // opcode fields and special registers
  assign hi = q.opc[7:4];
  assign lo = q.opc[3:0];
  assign rp = q.rf[bcie_p::RF_RP];
  assign sp = q.rf[bcie_p::RF_SP];
  assign flg = q.rf[bcie_p::RF_FLAGS];
  assign r_hi = {rp[7:4], q.op1[7:4]};
  assign r_lo = {rp[7:4], q.op1[3:0]};
  assign r_opc = {rp[7:4], hi};
  assign rr_a = {r_lo[7:1], 1'b0};
  assign d1 = wmap(q.op1, rp);
  assign d2 = wmap(q.op2, rp);

  // destination address and source value by addressing mode
  assign dst_a = (lo == bcie_p::LN_RR || lo == bcie_p::LN_RIR) ? r_hi :
                 (lo == bcie_p::LN_RR3 || lo == bcie_p::LN_RIRR) ? d2 :
                 (lo == bcie_p::LN_IR || lo == bcie_p::LN_IRIM) ? q.rf[d1] :
                 (lo == bcie_p::LN_INCR) ? r_opc : d1;
  assign src_v = (lo == bcie_p::LN_RR) ? q.rf[r_lo] :
                 (lo == bcie_p::LN_RIR) ? q.rf[q.rf[r_lo]] :
                 (lo == bcie_p::LN_RR3) ? q.rf[d1] :
                 (lo == bcie_p::LN_RIRR) ? q.rf[q.rf[d1]] : q.op2;

  // alu operation select
  assign un1 = (lo == bcie_p::LN_R) || (lo == bcie_p::LN_IR);
  assign alu_un = un1 || (lo == bcie_p::LN_INCR);
  assign alu_nib = (lo == bcie_p::LN_INCR) ? bcie_p::UN_INC : hi;
  assign alu_ok = (lo <= bcie_p::LN_IRIM) || (lo == bcie_p::LN_INCR);

  // program counter arithmetic
  assign pc_next = q.pc + ins_len(lo);
  assign pc_rel = pc_next + {{8{q.op1[bcie_p::MSB]}}, q.op1};

  // register pair word for the word increment and decrement
  assign wadr = {dst_a[7:1], 1'b0};
  assign wval = {q.rf[wadr], q.rf[wadr | bcie_p::ONE8]};
  assign wnew = (hi == bcie_p::UN_WORD_PLUS_ONE_OP) ? wval + bcie_p::LEN1 : wval - bcie_p::LEN1;

  // registered ready blocks a second take of the same access phase
  assign apb_acc = psel && penable && !q.pready;
  assign erf_i = q.reg_addr[1:0];

  bcie_alu u_alu (
    .unary (alu_un),
    .nib   (alu_nib),
    .a     (q.rf[dst_a]),
    .b     (src_v),
    .fin   (flg),
    .res   (alu_res),
    .fout  (alu_f),
    .wb    (alu_wb)
  );

  // next state: fetch, execute, then the register bus
  always_comb begin
    n = q;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    case (q.st)
      bcie_p::S_FETCH: begin
        // a halted core waits here until software writes the control word with the run bit set
        n.pmem_addr = q.pc;
        if (q.run && !q.halted) begin
          n.st = bcie_p::S_OPC;
        end
      end
      bcie_p::S_OPC: begin
        n.opc = pmem_rdata;
        n.pmem_addr = q.pc + bcie_p::LEN1;
        n.st = bcie_p::S_OP1;
      end
      bcie_p::S_OP1: begin
        n.op1 = pmem_rdata;
        n.pmem_addr = q.pc + bcie_p::LEN2;
        n.st = bcie_p::S_OP2;
      end
      bcie_p::S_OP2: begin
        n.op2 = pmem_rdata;
        n.st = bcie_p::S_EXEC;
      end
      bcie_p::S_EXEC: begin
        n.pc = pc_next;
        n.st = bcie_p::S_FETCH;
        // whole-opcode forms take priority over nibble decoding
        if (q.opc == bcie_p::OPC_CCF) begin
          n.rf[bcie_p::RF_FLAGS][bcie_p::FL_C] = ~flg[bcie_p::FL_C];
        end else if (q.opc == bcie_p::OPC_RCF) begin
          n.rf[bcie_p::RF_FLAGS][bcie_p::FL_C] = 1'b0;
        end else if (q.opc == bcie_p::OPC_SCF) begin
          n.rf[bcie_p::RF_FLAGS][bcie_p::FL_C] = 1'b1;
        end else if (q.opc == bcie_p::OPC_DI) begin
          n.rf[bcie_p::RF_IMR][bcie_p::IMR_EN] = 1'b0;
        end else if (q.opc == bcie_p::OPC_EI) begin
          n.rf[bcie_p::RF_IMR][bcie_p::IMR_EN] = 1'b1;
        end else if (q.opc == bcie_p::OPC_HALT) begin
          n.halted = 1'b1;
        end else if (q.opc == bcie_p::OPC_SRP) begin
          n.rf[bcie_p::RF_RP] = q.op1;
        end else if (q.opc == bcie_p::OPC_RET) begin
          n.pc = {q.rf[sp], q.rf[sp + bcie_p::ONE8]};
          n.rf[bcie_p::RF_SP] = sp + bcie_p::TWO8;
        end else if (q.opc == bcie_p::OPC_INTERRUPT_EXIT_OP) begin
          // flags sit on top, the return address just above them
          n.rf[bcie_p::RF_FLAGS] = q.rf[sp];
          n.pc = {q.rf[sp + bcie_p::ONE8], q.rf[sp + bcie_p::TWO8]};
          n.rf[bcie_p::RF_SP] = sp + bcie_p::THREE8;
          n.rf[bcie_p::RF_IMR][bcie_p::IMR_EN] = 1'b1;
        end else if (q.opc == bcie_p::OPC_CODE_LOAD_AUTOINC_OP) begin
          n.pmem_addr = {q.rf[rr_a], q.rf[rr_a | bcie_p::ONE8]};
          n.st = bcie_p::S_LDC;
        end else if (lo == bcie_p::LN_DJNZ) begin
          n.rf[r_opc] = q.rf[r_opc] - bcie_p::ONE8;
          // branch unless the count has just reached zero
          if (q.rf[r_opc] != bcie_p::ONE8) begin
            n.pc = pc_rel;
          end
        end else if (lo == bcie_p::LN_JR) begin
          if (cc_true(hi, flg)) begin
            n.pc = pc_rel;
          end
        end else if (lo == bcie_p::LN_LDIM) begin
          n.rf[r_opc] = q.op1;
        end else if (lo == bcie_p::LN_JP) begin
          if (cc_true(hi, flg)) begin
            n.pc = {q.op1, q.op2};
          end
        end else if (un1 && hi == bcie_p::UN_POP) begin
          n.rf[dst_a] = q.rf[sp];
          n.rf[bcie_p::RF_SP] = sp + bcie_p::ONE8;
        end else if (un1 && hi == bcie_p::UN_PUSH) begin
          // pointer moves down before the byte is stored
          n.rf[bcie_p::RF_SP] = sp - bcie_p::ONE8;
          n.rf[sp - bcie_p::ONE8] = q.rf[dst_a];
        end else if (un1 && (hi == bcie_p::UN_WORD_PLUS_ONE_OP || hi == bcie_p::UN_DECW)) begin
          // carry is left alone, z s v follow the whole word
          n.rf[bcie_p::RF_FLAGS][bcie_p::FL_Z] = (wnew == '0);
          n.rf[bcie_p::RF_FLAGS][bcie_p::FL_S] = wnew[15];
          n.rf[bcie_p::RF_FLAGS][bcie_p::FL_V] = (wnew[15] ^ wval[15]) &
                                                  (wval[15] ^ (hi == bcie_p::UN_WORD_PLUS_ONE_OP));
          {n.rf[wadr], n.rf[wadr | bcie_p::ONE8]} = wnew;
        end else if (alu_ok) begin
          n.rf[bcie_p::RF_FLAGS] = alu_f;
          if (alu_wb) begin
            n.rf[dst_a] = alu_res;
          end
        end
      end
      bcie_p::S_LDC: begin
        // code byte addressed in the execute cycle arrives now
        n.rf[q.rf[r_hi]] = pmem_rdata;
        n.rf[r_hi] = q.rf[r_hi] + bcie_p::ONE8;
        {n.rf[rr_a], n.rf[rr_a | bcie_p::ONE8]} =
          {q.rf[rr_a], q.rf[rr_a | bcie_p::ONE8]} + bcie_p::LEN1;
        n.st = bcie_p::S_FETCH;
      end
      default: n.st = bcie_p::S_FETCH;
    endcase

    // apb access phase, answered one cycle later
    if (apb_acc) begin
      n.pready = 1'b1;
      case (paddr)
        bcie_p::APB_CTRL: begin
          if (pwrite) begin
            n.run = pwdata[bcie_p::CTRL_RUN];
            n.halted = 1'b0;
          end
          n.prdata = 32'(q.run);
        end
        bcie_p::APB_STATUS: begin
          n.prdata = {flg, 7'h00, q.halted, q.pc};
        end
        bcie_p::APB_RADDR: begin
          if (pwrite) begin
            n.reg_addr = pwdata[8:0];
          end
          n.prdata = 32'(q.reg_addr);
        end
        bcie_p::APB_RDATA: begin
          // top address bit selects the expanded space
          if (!q.reg_addr[bcie_p::RADDR_ERF]) begin
            n.prdata = 32'(q.rf[q.reg_addr[7:0]]);
            if (pwrite) begin
              n.rf[q.reg_addr[7:0]] = pwdata[7:0];
            end
          end else if (32'(erf_i) < bcie_p::ERF_COUNT) begin
            n.prdata = 32'(q.erf[erf_i]);
            if (pwrite) begin
              n.erf[erf_i] = pwdata[7:0];
            end
          end else begin
            n.prdata = '0;
          end
        end
        default: begin
          n.prdata = '0;
          n.pslverr = 1'b1;
        end
      endcase
    end

    // absent port and reserved control slots hold no storage
    n.rf[bcie_p::RF_PORT1] = '0;
    n.rf[bcie_p::RF_RSV0] = '0;
    n.rf[bcie_p::RF_RSV1] = '0;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      // program counter and fetch address start at the reset vector
      q.pc <= RESET_PC;
      q.pmem_addr <= RESET_PC;
    end else begin
      q <= n;
    end
  end

  // outputs straight from state flops
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign pmem_addr = q.pmem_addr;
endmodule : bcie_core

/* hw/bcie_p.sv */
package bcie_p;
  // apb map and register fields
  localparam int APB_AW = 12;
  localparam logic [11:0] APB_CTRL = 12'h000, APB_STATUS = 12'h004;
  localparam logic [11:0] APB_RADDR = 12'h008, APB_RDATA = 12'h00c;
  localparam int CTRL_RUN = 0, STAT_HALT = 16, RADDR_ERF = 8, MSB = 7;
  // register file map
  localparam int RF_SIZE = 256, ERF_COUNT = 3;
  localparam logic [7:0] RF_PORT1 = 8'h01, RF_RSV0 = 8'hf0, RF_RSV1 = 8'hfe;
  localparam logic [7:0] RF_IMR = 8'hfb, RF_FLAGS = 8'hfc, RF_RP = 8'hfd, RF_SP = 8'hff;
  localparam int FL_C = 7, FL_Z = 6, FL_S = 5, FL_V = 4, IMR_EN = 7;
  localparam logic [3:0] WREG_NIB = 4'he;
  // arithmetic steps and limits
  localparam logic [7:0] ONE8 = 8'h01, TWO8 = 8'h02, THREE8 = 8'h03;
  localparam logic [7:0] NEG_MIN = 8'h80, POS_MAX = 8'h7f;
  localparam logic [15:0] LEN1 = 16'h0001, LEN2 = 16'h0002, LEN3 = 16'h0003;
  // lower opcode nibble
  localparam logic [3:0] LN_R = 4'h0, LN_IR = 4'h1, LN_RR = 4'h2, LN_RIR = 4'h3;
  localparam logic [3:0] LN_RR3 = 4'h4, LN_RIRR = 4'h5, LN_RIM = 4'h6, LN_IRIM = 4'h7;
  localparam logic [3:0] LN_DJNZ = 4'ha, LN_JR = 4'hb, LN_LDIM = 4'hc, LN_JP = 4'hd;
  localparam logic [3:0] LN_INCR = 4'he, LN_ONE = 4'hf;
  // upper nibble of two-operand operations
  localparam logic [3:0] OP_ADD = 4'h0, OP_ADC = 4'h1, OP_SUB = 4'h2, OP_SBC = 4'h3;
  localparam logic [3:0] OP_OR = 4'h4, OP_AND = 4'h5, OP_TCM = 4'h6, OP_TM = 4'h7;
  localparam logic [3:0] OP_CP = 4'ha, OP_XOR = 4'hb;
  // upper nibble of one-operand operations
  localparam logic [3:0] UN_DEC = 4'h0, UN_RLC = 4'h1, UN_INC = 4'h2, UN_POP = 4'h5;
  localparam logic [3:0] UN_COM = 4'h6, UN_PUSH = 4'h7, UN_DECW = 4'h8, UN_RL = 4'h9;
  localparam logic [3:0] UN_WORD_PLUS_ONE_OP = 4'ha, UN_CLR = 4'hb, UN_RRC = 4'hc, UN_SRA = 4'hd;
  localparam logic [3:0] UN_RR = 4'he, UN_SWAP = 4'hf;
  // whole opcodes
  localparam logic [7:0] OPC_SRP = 8'h31, OPC_HALT = 8'h7f, OPC_DI = 8'h8f;
  localparam logic [7:0] OPC_EI = 8'h9f, OPC_RET = 8'haf, OPC_INTERRUPT_EXIT_OP = 8'hbf;
  localparam logic [7:0] OPC_CODE_LOAD_AUTOINC_OP = 8'hc3, OPC_RCF = 8'hcf, OPC_SCF = 8'hdf;
  localparam logic [7:0] OPC_CCF = 8'hef;

  typedef enum logic [2:0] {
    S_FETCH = 3'b000,
    S_OPC   = 3'b001,
    S_OP1   = 3'b010,
    S_OP2   = 3'b011,
    S_EXEC  = 3'b100,
    S_LDC   = 3'b101
  } bcie_state_t;

  typedef struct packed {
    bcie_state_t                st;
    logic [15:0]                pc;
    logic [7:0]                 opc;
    logic [7:0]                 op1;
    logic [7:0]                 op2;
    logic [RF_SIZE-1:0][7:0]    rf;
    logic [ERF_COUNT-1:0][7:0]  erf;
    logic [15:0]                pmem_addr;
    logic                       run;
    logic                       halted;
    logic [8:0]                 reg_addr;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
  } bcie_core_t;
endpackage : bcie_p

/* hw/bcie_alu.sv */
`timescale 1ns/1ns
module bcie_alu (
  // operation select
  input  wire logic       unary,
  input  wire logic [3:0] nib,
  // operands and incoming flags
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic [7:0] fin,
  // result
  output logic [7:0]      res,
  output logic [7:0]      fout,
  output logic            wb
);
  logic [8:0] s9;
  logic       c;
  logic       zs;

  // byte operations and their flag effects
  always_comb begin
    c = fin[bcie_p::FL_C];
    s9 = '0;
    res = a;
    fout = fin;
    wb = 1'b1;
    zs = 1'b1;
    if (!unary) begin
      case (nib)
        bcie_p::OP_ADD, bcie_p::OP_ADC: begin
          s9 = {1'b0, a} + {1'b0, b} + 9'(c & (nib == bcie_p::OP_ADC));
          res = s9[7:0];
          fout[bcie_p::FL_C] = s9[8];
          fout[bcie_p::FL_V] = (a[bcie_p::MSB] == b[bcie_p::MSB]) &&
                               (res[bcie_p::MSB] != a[bcie_p::MSB]);
        end
        bcie_p::OP_SUB, bcie_p::OP_SBC, bcie_p::OP_CP: begin
          s9 = {1'b0, a} - {1'b0, b} - 9'(c & (nib == bcie_p::OP_SBC));
          res = s9[7:0];
          fout[bcie_p::FL_C] = s9[8];
          fout[bcie_p::FL_V] = (a[bcie_p::MSB] != b[bcie_p::MSB]) &&
                               (res[bcie_p::MSB] != a[bcie_p::MSB]);
          wb = (nib != bcie_p::OP_CP);
        end
        bcie_p::OP_OR: begin
          res = a | b;
          fout[bcie_p::FL_V] = 1'b0;
        end
        bcie_p::OP_AND: begin
          res = a & b;
          fout[bcie_p::FL_V] = 1'b0;
        end
        bcie_p::OP_TCM, bcie_p::OP_TM: begin
          res = (nib == bcie_p::OP_TCM) ? (~a & b) : (a & b);
          fout[bcie_p::FL_V] = 1'b0;
          wb = 1'b0;
        end
        bcie_p::OP_XOR: begin
          res = a ^ b;
          fout[bcie_p::FL_V] = 1'b0;
        end
        default: begin
          wb = 1'b0;
          zs = 1'b0;
        end
      endcase
    end else begin
      case (nib)
        bcie_p::UN_DEC: begin
          res = a - bcie_p::ONE8;
          fout[bcie_p::FL_V] = (a == bcie_p::NEG_MIN);
        end
        bcie_p::UN_INC: begin
          res = a + bcie_p::ONE8;
          fout[bcie_p::FL_V] = (a == bcie_p::POS_MAX);
        end
        bcie_p::UN_COM: begin
          res = ~a;
          fout[bcie_p::FL_V] = 1'b0;
        end
        bcie_p::UN_CLR: begin
          res = '0;
          zs = 1'b0;
        end
        bcie_p::UN_RL, bcie_p::UN_RLC: begin
          res = {a[6:0], (nib == bcie_p::UN_RL) ? a[bcie_p::MSB] : c};
          fout[bcie_p::FL_C] = a[bcie_p::MSB];
          fout[bcie_p::FL_V] = res[bcie_p::MSB] ^ a[bcie_p::MSB];
        end
        bcie_p::UN_RR, bcie_p::UN_RRC, bcie_p::UN_SRA: begin
          res = {(nib == bcie_p::UN_RR) ? a[0] :
                 (nib == bcie_p::UN_RRC) ? c : a[bcie_p::MSB], a[7:1]};
          fout[bcie_p::FL_C] = a[0];
          fout[bcie_p::FL_V] = res[bcie_p::MSB] ^ a[bcie_p::MSB];
        end
        bcie_p::UN_SWAP: res = {a[3:0], a[7:4]};
        default: begin
          wb = 1'b0;
          zs = 1'b0;
        end
      endcase
    end
    if (zs) begin
      fout[bcie_p::FL_Z] = (res == '0);
      fout[bcie_p::FL_S] = res[bcie_p::MSB];
    end
  end
endmodule : bcie_alu

/* test/bcie_core_checker.sv */
`timescale 1ns/1ns
module bcie_core_checker #(
  parameter logic [15:0] RESET_PC = 16'h0000
) (
  // clock and reset
  input wire logic                      pclk,
  input wire logic                      presetn,
  // apb slave
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [bcie_p::APB_AW-1:0] paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  // program memory
  input wire logic [15:0]               pmem_addr,
  input wire logic [7:0]                pmem_rdata
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic       tk;
  logic       mapped;
  logic [8:0] raddr_q;
  logic       ran_q;

  // a transfer is taken on the first access edge
  assign tk = psel && penable && !pready;
  assign mapped = paddr inside {bcie_p::APB_CTRL, bcie_p::APB_STATUS, bcie_p::APB_RADDR,
                                bcie_p::APB_RDATA};

  // remembers the selected register and whether software started the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raddr_q <= 9'h000;
      ran_q   <= 1'b0;
    end else if (tk && pwrite) begin
      if (paddr == bcie_p::APB_RADDR) raddr_q <= pwdata[8:0];
      if (paddr == bcie_p::APB_CTRL && pwdata[0]) ran_q <= 1'b1;
    end
  end

  property p_ready_next;
    tk |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("ready late");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  property p_ready_cause;
    pready |-> $past(psel && penable);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
  property p_err_pair;
    pslverr |-> pready;
  endproperty
  a_err_pair: assert property (p_err_pair) else $error("error without ready");
  property p_unmapped;
    tk && !mapped |=> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_mapped;
    tk && mapped |=> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped refused");
  property p_rdata_hold;
    !pready |-> $stable(prdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_reserved;
    tk && !pwrite && paddr == bcie_p::APB_RDATA
      && raddr_q inside {9'h001, 9'h0f0, 9'h0fe} |=> prdata == 32'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved byte not zero");
  property p_idle;
    !ran_q |-> pmem_addr == RESET_PC;
  endproperty
  a_idle: assert property (p_idle) else $error("core fetched before start");

  // main traffic
  c_write: cover property (tk && pwrite);
  c_read:  cover property (pready && !pslverr && prdata != 32'h0);
  c_err:   cover property (pslverr);
endmodule : bcie_core_checker

bind bcie_core bcie_core_checker #(.RESET_PC(RESET_PC)) bcie_core_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata)
);

/* test/bcie_pmem.sv */
`timescale 1ns/1ns
module bcie_pmem (
  // program memory port
  input  wire logic [15:0] pmem_addr,
  output logic [7:0]       pmem_rdata
);
  logic [7:0] mem [0:255];

  // same-cycle read; outside the loaded page the byte follows the address
  always_comb begin
    if (pmem_addr[15:8] == 8'h00) pmem_rdata = mem[pmem_addr[7:0]];
    else pmem_rdata = ~pmem_addr[7:0];
  end
endmodule : bcie_pmem

/* test/bcie_core_bench.sv */
`timescale 1ns/1ns
module bcie_core_bench;
  typedef struct {logic cd; logic ee; logic [31:0] ed;} bcie_exp_t;
  // program at 0x00, jump target page at 0x60
  localparam logic [239:0] PROG = 240'h3120df2010ef70fc601100127010501350154245a254cf70fc5014c368bf;
  localparam logic [63:0]  PROG2 = 64'h7b037fffffa030af;
  // register presets and final contents, address then byte
  localparam logic [239:0] PRE = 240'h107f11ff1280240f25f0264028002970307f31ff80c0810082608462ff80;
  localparam logic [319:0] EXP = {64'h10801100127f1380, 64'h1420153024ff25f0,
                                  64'h2641280029713080, 64'h3100405a7e807f20, 64'hfb80fcb0fd20ff85};

  logic                      pclk;
  logic                      presetn;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic [bcie_p::APB_AW-1:0] paddr;
  logic [31:0]               pwdata;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic [15:0]               pmem_addr;
  logic [7:0]                pmem_rdata;
  bcie_exp_t                 expq[$];
  bcie_exp_t                 e;
  logic [31:0]               rdat;
  logic [31:0]               seed;
  logic [8:0]                ra;
  int                        n_mismatch;
  int                        checks_done;
  int                        i;
  int                        n;

  bcie_core bcie_core_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata)
  );
  bcie_pmem bcie_pmem_inst (.pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // one apb transfer; the answer is noted first and judged by the monitor
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic cd, input logic ee, input logic [31:0] ed);
    int k;
    k = 0;
    expq.push_back('{cd, ee, ed});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // hold the request until ready is seen high at a rising edge
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdat = prdata;
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("Error %0t no ready", $time);
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic wreg(input logic [8:0] a, input logic [7:0] v);
    xfer(1'b1, bcie_p::APB_RADDR, {23'h0, a}, 1'b0, 1'b0, 32'h0);
    xfer(1'b1, bcie_p::APB_RDATA, {24'h0, v}, 1'b0, 1'b0, 32'h0);
  endtask : wreg

  task automatic rreg(input logic [8:0] a, input logic [7:0] v);
    xfer(1'b1, bcie_p::APB_RADDR, {23'h0, a}, 1'b0, 1'b0, 32'h0);
    xfer(1'b0, bcie_p::APB_RDATA, 32'h0, 1'b1, 1'b0, {24'h0, v});
  endtask : rreg

  // clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // bound on the whole run
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    $display("Error %0t run timeout", $time);
    conclude();
  end

  // compare each answer with the oldest note
  always @(negedge pclk) begin
    if (pready === 1'b1) begin
      checks_done++;
      if (expq.size() == 0) begin
        n_mismatch++;
        $display("Error %0t answer with no request", $time);
      end else begin
        e = expq.pop_front();
        if (pslverr !== e.ee || (e.cd && prdata !== e.ed)) begin
          n_mismatch++;
          $display("Error %0t got %h/%b want %h/%b", $time, prdata, pslverr, e.ed, e.ee);
        end
      end
    end
  end

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    n_mismatch = 0;
    checks_done = 0;
    seed = 32'h42eb;
    for (i = 0; i < 256; i++) bcie_pmem_inst.mem[i] = 8'hff;
    for (i = 0; i < 30; i++) bcie_pmem_inst.mem[i] = PROG[8*(29-i) +: 8];
    for (i = 0; i < 8; i++) bcie_pmem_inst.mem[8'h60+i] = PROG2[8*(7-i) +: 8];
    bcie_pmem_inst.mem[8'h70] = 8'h5a;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, bcie_p::APB_STATUS, 32'h0, 1'b1, 1'b0, 32'h0);
    for (i = 0; i < 15; i++) wreg({1'b0, PRE[16*(14-i)+8 +: 8]}, PRE[16*(14-i) +: 8]);
    xfer(1'b1, bcie_p::APB_CTRL, 32'h1, 1'b0, 1'b0, 32'h0);
    n = 0;
    while (rdat[bcie_p::STAT_HALT] !== 1'b1 && n < 200) begin
      xfer(1'b0, bcie_p::APB_STATUS, 32'h0, 1'b0, 1'b0, 32'h0);
      n++;
    end
    if (n >= 200) begin
      n_mismatch++;
      $display("Error %0t core never halted", $time);
      conclude();
    end
    xfer(1'b0, bcie_p::APB_STATUS, 32'h0, 1'b1, 1'b0, {8'hb0, 7'h00, 1'b1, 16'h0063});
    // every executed operation except the relative jump, the compare and the halt leaves its trace in the register file
    for (i = 0; i < 20; i++) rreg({1'b0, EXP[16*(19-i)+8 +: 8]}, EXP[16*(19-i) +: 8]);
    // random bytes in plain and expanded registers
    for (i = 0; i < 7; i++) begin
      seed = xs(seed);
      ra = (i < 4) ? {1'b0, 4'h5, seed[3:0]} : {1'b1, 6'h0, 2'(i - 4)};
      wreg(ra, seed[15:8]);
      rreg(ra, seed[15:8]);
    end
    // reserved bytes ignore writes
    for (i = 0; i < 3; i++) begin
      seed = xs(seed);
      ra = (i == 0) ? 9'h001 : ((i == 1) ? 9'h0f0 : 9'h0fe);
      wreg(ra, seed[7:0]);
      rreg(ra, 8'h00);
    end
    xfer(1'b0, 12'h010, 32'h0, 1'b1, 1'b1, 32'h0);
    xfer(1'b1, 12'h7fc, seed, 1'b1, 1'b1, 32'h0);
    conclude();
  end
endmodule : bcie_core_bench
